// ---- flash_seq_pkg.sv ----
package flash_seq_pkg;

	// ****************************************************************
	// Bus map
	// ****************************************************************
	localparam int          ADDR_W         = 17;
	localparam int          DATA_W         = 32;
	localparam int          ARRAY_SEL_BIT  = 16;
	localparam logic [16:0] DIV_OFS        = 17'h00000;
	localparam logic [16:0] STAT_OFS       = 17'h00004;
	localparam logic [16:0] CMD_OFS        = 17'h00008;

	// ****************************************************************
	// Field positions and reset values
	// ****************************************************************
	localparam int         DIV_VAL_LSB     = 0;
	localparam int         DIV_VAL_W       = 6;
	localparam int         DIV_PRE8_BIT    = 6;
	localparam int         DIV_DONE_BIT    = 7;
	localparam int         STAT_CBEF_BIT   = 7;
	localparam int         STAT_CCF_BIT    = 6;
	localparam int         STAT_ACCERR_BIT = 4;
	localparam int         STAT_BLANK_BIT  = 2;
	localparam logic [5:0] DIV_VAL_RESET   = 6'h00;
	localparam int         PAGE_LSB        = 9;
	localparam int         ROW_LSB         = 6;
	localparam logic [9:0] PRE8_FACTOR     = 10'h008;

	// ****************************************************************
	// Command codes
	// ****************************************************************
	localparam logic [7:0] CMD_BLANK = 8'h05;
	localparam logic [7:0] CMD_BYTE  = 8'h20;
	localparam logic [7:0] CMD_BURST = 8'h25;
	localparam logic [7:0] CMD_PAGE  = 8'h40;
	localparam logic [7:0] CMD_MASS  = 8'h41;
	localparam logic [7:0] CMD_RESET = 8'h00;

	// ****************************************************************
	// Durations in timing clock periods
	// ****************************************************************
	localparam logic [14:0] BYTE_TICKS  = 15'h0009;
	localparam logic [14:0] BURST_TICKS = 15'h0004;
	localparam int          PAGE_TICKS  = 4000;
	localparam int          MASS_TICKS  = 20000;
	localparam logic [14:0] BLANK_TICKS = 15'h0010;

	typedef enum logic [1:0] {SEQ_IDLE, SEQ_ADDR, SEQ_CMD} seq_state_type;

	function automatic logic isValidCmd(input logic [7:0] code);
		return code == CMD_BLANK || code == CMD_BYTE || code == CMD_BURST ||
			code == CMD_PAGE || code == CMD_MASS;
	endfunction : isValidCmd

endpackage : flash_seq_pkg

// ---- flash_timing_if.sv ----
`timescale 1ns/10ps
interface flash_timing_if;
	logic [5:0]  divValue;
	logic        pre8;
	logic        divReady;
	logic        start;
	logic [14:0] ticks;
	logic        abort;
	logic        busy;
	logic        done;

	modport seq (output divValue, pre8, divReady, start, ticks, abort,
		input busy, done);
	modport timer (input divValue, pre8, divReady, start, ticks, abort,
		output busy, done);
endinterface : flash_timing_if

// ---- flash_pulse_timer.sv ----
`timescale 1ns/10ps
module flash_pulse_timer (
	input wire logic     mclk,
	input wire logic     sys_rst,
	flash_timing_if.timer tim
);

	logic [9:0]  preCnt_reg;
	logic [9:0]  preLimit;
	logic        tick;
	logic [14:0] remain_reg;
	logic        busy_reg;
	logic        done_reg;

	// Timing clock period in bus cycles: (div+1), times 8 when prescaled
	always_comb begin
		preLimit = {4'h0, tim.divValue} + 10'h001;
		if (tim.pre8)
			preLimit = 10'(preLimit * flash_seq_pkg::PRE8_FACTOR);
		preLimit = preLimit - 10'h001;
	end

	assign tick = tim.divReady && preCnt_reg == preLimit;

	// Restarted at each command start so a pulse spans whole periods
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst)
			preCnt_reg <= 10'h000;
		else if (!tim.divReady || tim.start || tick)
			preCnt_reg <= 10'h000;
		else
			preCnt_reg <= preCnt_reg + 10'h001;
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			busy_reg   <= 1'b0;
			remain_reg <= 15'h0000;
			done_reg   <= 1'b0;
		end else begin
			done_reg <= 1'b0;
			if (tim.start) begin
				busy_reg   <= 1'b1;
				remain_reg <= tim.ticks;
			end else if (tim.abort) begin
				busy_reg <= 1'b0;
			end else if (busy_reg && tick) begin
				remain_reg <= remain_reg - 15'h0001;
				if (remain_reg == 15'h0001) begin
					busy_reg <= 1'b0;
					done_reg <= 1'b1;
				end
			end
		end
	end

	assign tim.busy = busy_reg;
	assign tim.done = done_reg;

endmodule : flash_pulse_timer

// ---- flash_command_sequencer.sv ----
// The Avalon-MM register port and the register addresses were left to the implementer.
`timescale 1ns/10ps
module flash_command_sequencer #(
	parameter int PAGE_ERASE_TICKS = flash_seq_pkg::PAGE_TICKS,
	parameter int MASS_ERASE_TICKS = flash_seq_pkg::MASS_TICKS
) (
	input  wire logic        mclk,
	input  wire logic        sys_rst,
	input  wire logic [16:0] avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        stopRequest,
	input  wire logic        arrayBlank,
	output logic      [7:0]  flashCmd,
	output logic      [15:0] flashAddr,
	output logic      [7:0]  flashData,
	output logic             opActive,
	output logic             hvEnable
);

	// ****************************************************************
	// Declarations
	// ****************************************************************
	flash_timing_if tim ();

	logic                        stopMeta_reg;
	logic                        stopSync_reg;
	logic                        ack_reg;
	logic [31:0]                 readdata_reg;
	logic                        accept;
	logic                        wrAcc;
	logic                        wrArray;
	logic                        wrDiv;
	logic                        wrStat;
	logic                        wrCmd;
	logic [5:0]                  divValue_reg;
	logic                        divPre8_reg;
	logic                        divDone_reg;
	flash_seq_pkg::seq_state_type seqState_reg;
	flash_seq_pkg::seq_state_type seqState_next;
	logic [15:0]                 stageAddr_reg;
	logic [7:0]                  stageData_reg;
	logic [7:0]                  stageCmd_reg;
	logic                        pendValid_reg;
	logic                        pendFast_reg;
	logic                        execBusy_reg;
	logic [7:0]                  execCmd_reg;
	logic [15:0]                 execAddr_reg;
	logic [7:0]                  execData_reg;
	logic                        accErr_reg;
	logic                        blank_reg;
	logic                        cbef;
	logic                        ccf;
	logic                        launch;
	logic                        startNow;
	logic                        startPend;
	logic                        stopAbort;
	logic                        errSet;
	logic                        chainOk;
	logic [7:0]                  statusByte;

	// Cycles of the timing clock for one command
	function automatic logic [14:0] cmdTicks(input logic [7:0] code,
		input logic fast);
		logic [14:0] t;
		t = flash_seq_pkg::BLANK_TICKS;
		if (code == flash_seq_pkg::CMD_BYTE)
			t = flash_seq_pkg::BYTE_TICKS;
		else if (code == flash_seq_pkg::CMD_BURST)
			t = fast ? flash_seq_pkg::BURST_TICKS
				: flash_seq_pkg::BYTE_TICKS;
		else if (code == flash_seq_pkg::CMD_PAGE)
			t = 15'(PAGE_ERASE_TICKS);
		else if (code == flash_seq_pkg::CMD_MASS)
			t = 15'(MASS_ERASE_TICKS);
		return t;
	endfunction : cmdTicks

	// ****************************************************************
	// Stop request synchroniser
	// ****************************************************************
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			stopMeta_reg <= 1'b0;
			stopSync_reg <= 1'b0;
		end else begin
			stopMeta_reg <= stopRequest;
			stopSync_reg <= stopMeta_reg;
		end
	end

	// ****************************************************************
	// Avalon slave: one wait cycle, then the access completes
	// ****************************************************************
	assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
	assign accept          = (avs_read || avs_write) && ack_reg;
	assign wrAcc           = accept && avs_write && avs_byteenable[0];
	assign wrArray         = wrAcc && avs_address[flash_seq_pkg::ARRAY_SEL_BIT];
	assign wrDiv           = wrAcc && avs_address == flash_seq_pkg::DIV_OFS;
	assign wrStat          = wrAcc && avs_address == flash_seq_pkg::STAT_OFS;
	assign wrCmd           = wrAcc && avs_address == flash_seq_pkg::CMD_OFS;

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst)
			ack_reg <= 1'b0;
		else
			ack_reg <= (avs_read || avs_write) && !ack_reg;
	end

	assign cbef = !pendValid_reg;
	assign ccf  = !execBusy_reg && !pendValid_reg;

	always_comb begin
		statusByte = 8'h00;
		statusByte[flash_seq_pkg::STAT_CBEF_BIT]   = cbef;
		statusByte[flash_seq_pkg::STAT_CCF_BIT]    = ccf;
		statusByte[flash_seq_pkg::STAT_ACCERR_BIT] = accErr_reg;
		statusByte[flash_seq_pkg::STAT_BLANK_BIT]  = blank_reg;
	end

	// Read data is settled during the wait cycle so it stands at the ack
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			readdata_reg <= 32'h00000000;
		end else if (avs_read && !ack_reg) begin
			unique case (avs_address)
				flash_seq_pkg::DIV_OFS:
					readdata_reg <= {24'h000000, divDone_reg, divPre8_reg,
						divValue_reg};
				flash_seq_pkg::STAT_OFS:
					readdata_reg <= {24'h000000, statusByte};
				flash_seq_pkg::CMD_OFS:
					readdata_reg <= {24'h000000, stageCmd_reg};
				default:
					readdata_reg <= 32'h00000000;
			endcase
		end
	end

	assign avs_readdata = readdata_reg;

	// ****************************************************************
	// Clock divider
	// ****************************************************************
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			divValue_reg <= flash_seq_pkg::DIV_VAL_RESET;
			divPre8_reg  <= 1'b0;
			divDone_reg  <= 1'b0;
		end else if (wrDiv && !divDone_reg && !accErr_reg &&
			seqState_reg == flash_seq_pkg::SEQ_IDLE) begin
			divValue_reg <= avs_writedata[flash_seq_pkg::DIV_VAL_LSB +:
				flash_seq_pkg::DIV_VAL_W];
			divPre8_reg  <= avs_writedata[flash_seq_pkg::DIV_PRE8_BIT];
			divDone_reg  <= 1'b1;
		end
	end

	// ****************************************************************
	// Command sequence checking
	// ****************************************************************
	assign launch = wrStat && avs_writedata[flash_seq_pkg::STAT_CBEF_BIT] &&
		seqState_reg == flash_seq_pkg::SEQ_CMD && !accErr_reg;
	assign stopAbort = stopSync_reg && execBusy_reg;

	// Any step out of order raises the error; a raised error blocks all
	always_comb begin
		errSet = stopAbort;
		if (!accErr_reg) begin
			if (wrArray && (!divDone_reg || !cbef ||
				seqState_reg != flash_seq_pkg::SEQ_IDLE))
				errSet = 1'b1;
			if (wrCmd && (seqState_reg != flash_seq_pkg::SEQ_ADDR))
				errSet = 1'b1;
			if (wrCmd && !flash_seq_pkg::isValidCmd(avs_writedata[7:0]))
				errSet = 1'b1;
			if (wrDiv && seqState_reg != flash_seq_pkg::SEQ_IDLE)
				errSet = 1'b1;
			if (wrStat && seqState_reg != flash_seq_pkg::SEQ_IDLE &&
				!launch)
				errSet = 1'b1;
		end
	end

	always_comb begin
		seqState_next = seqState_reg;
		if (errSet || launch)
			seqState_next = flash_seq_pkg::SEQ_IDLE;
		else if (wrArray && !accErr_reg)
			seqState_next = flash_seq_pkg::SEQ_ADDR;
		else if (wrCmd && !accErr_reg)
			seqState_next = flash_seq_pkg::SEQ_CMD;
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst)
			seqState_reg <= flash_seq_pkg::SEQ_IDLE;
		else
			seqState_reg <= seqState_next;
	end

	// Command buffer: address, data and code held until launch
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			stageAddr_reg <= 16'h0000;
			stageData_reg <= 8'h00;
			stageCmd_reg  <= flash_seq_pkg::CMD_RESET;
		end else begin
			if (wrArray && !errSet && !accErr_reg) begin
				stageAddr_reg <= avs_address[15:0];
				stageData_reg <= avs_writedata[7:0];
			end
			if (wrCmd && !errSet && !accErr_reg)
				stageCmd_reg <= avs_writedata[7:0];
		end
	end

	// ****************************************************************
	// Error and blank flags
	// ****************************************************************
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst)
			accErr_reg <= 1'b0;
		else if (errSet)
			accErr_reg <= 1'b1;
		else if (wrStat && avs_writedata[flash_seq_pkg::STAT_ACCERR_BIT])
			accErr_reg <= 1'b0;
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst)
			blank_reg <= 1'b0;
		else if (tim.done && execCmd_reg == flash_seq_pkg::CMD_BLANK)
			blank_reg <= arrayBlank;
		else if (launch)
			blank_reg <= 1'b0;
	end

	// ****************************************************************
	// Execution: one running command and one queued behind it
	// ****************************************************************
	// A queued burst byte gets the shorter burst time only on the same row
	assign chainOk = execBusy_reg &&
		execCmd_reg == flash_seq_pkg::CMD_BURST &&
		stageCmd_reg == flash_seq_pkg::CMD_BURST &&
		stageAddr_reg == execAddr_reg + 16'h0001 &&
		stageAddr_reg[flash_seq_pkg::ROW_LSB-1:0] != '0;
	assign startNow  = launch && !execBusy_reg;
	assign startPend = pendValid_reg && tim.done && !stopAbort;

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			pendValid_reg <= 1'b0;
			pendFast_reg  <= 1'b0;
		end else if (stopAbort) begin
			pendValid_reg <= 1'b0;
		end else if (launch && execBusy_reg) begin
			pendValid_reg <= 1'b1;
			pendFast_reg  <= chainOk;
		end else if (startPend) begin
			pendValid_reg <= 1'b0;
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			execBusy_reg <= 1'b0;
			execCmd_reg  <= flash_seq_pkg::CMD_RESET;
			execAddr_reg <= 16'h0000;
			execData_reg <= 8'h00;
		end else if (startNow || startPend) begin
			execBusy_reg <= 1'b1;
			execCmd_reg  <= stageCmd_reg;
			execData_reg <= stageData_reg;
			if (stageCmd_reg == flash_seq_pkg::CMD_PAGE)
				execAddr_reg <= {stageAddr_reg[15:flash_seq_pkg::PAGE_LSB],
					9'h000};
			else
				execAddr_reg <= stageAddr_reg;
		end else if (stopAbort || tim.done) begin
			execBusy_reg <= 1'b0;
		end
	end

	// Pump stays on between chained bursts; blank check needs no voltage
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst)
			hvEnable <= 1'b0;
		else if (startNow || startPend)
			hvEnable <= stageCmd_reg != flash_seq_pkg::CMD_BLANK;
		else if (stopAbort || tim.done)
			hvEnable <= 1'b0;
	end

	assign flashCmd  = execCmd_reg;
	assign flashAddr = execAddr_reg;
	assign flashData = execData_reg;
	assign opActive  = execBusy_reg;

	// ****************************************************************
	// Pulse timer
	// ****************************************************************
	assign tim.divValue = divValue_reg;
	assign tim.pre8     = divPre8_reg;
	assign tim.divReady = divDone_reg;
	assign tim.start    = startNow || startPend;
	assign tim.ticks    = cmdTicks(stageCmd_reg, startPend && pendFast_reg);
	assign tim.abort    = stopAbort;

	flash_pulse_timer timer (
		.mclk    (mclk),
		.sys_rst (sys_rst),
		.tim     (tim)
	);

endmodule : flash_command_sequencer

// ---- flash_command_sequencer_props.sv ----
`timescale 1ns/10ps
// ****************************************************************
// Port checker
// ****************************************************************
module flash_command_sequencer_props (
	input wire logic        mclk,
	input wire logic        sys_rst,
	input wire logic [16:0] avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0]  avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic        stopRequest,
	input wire logic        arrayBlank,
	input wire logic [7:0]  flashCmd,
	input wire logic [15:0] flashAddr,
	input wire logic [7:0]  flashData,
	input wire logic        opActive,
	input wire logic        hvEnable
);
	logic launchWr;
	logic launchPending;
	logic opPrev;

	assign launchWr = avs_write && !avs_waitrequest && avs_byteenable[0] &&
		avs_address == flash_seq_pkg::STAT_OFS && avs_writedata[7];

	// Pending stays up until opActive rises; a queued start, with no rise, is not checked
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			launchPending <= 1'h0;
			opPrev        <= 1'h0;
		end else begin
			opPrev <= opActive;
			if (launchWr)
				launchPending <= 1'h1;
			else if (opActive && !opPrev)
				launchPending <= 1'h0;
		end
	end

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (sys_rst);

	property p_waitOne;
		$rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest;
	endproperty
	a_waitOne: assert property (p_waitOne) else $error("bus answer late");
	property p_hvInOp;
		hvEnable |-> opActive || $past(opActive);
	endproperty
	a_hvInOp: assert property (p_hvInOp) else $error("high voltage idle");
	property p_blankNoHv;
		opActive && flashCmd == flash_seq_pkg::CMD_BLANK |-> !hvEnable;
	endproperty
	a_blankNoHv: assert property (p_blankNoHv) else $error("blank uses hv");
	property p_pageAlign;
		opActive && flashCmd == flash_seq_pkg::CMD_PAGE |->
			flashAddr[8:0] == 9'h000;
	endproperty
	a_pageAlign: assert property (p_pageAlign) else $error("page unaligned");
	property p_cmdKnown;
		opActive |-> flashCmd inside {8'h05, 8'h20, 8'h25, 8'h40, 8'h41};
	endproperty
	a_cmdKnown: assert property (p_cmdKnown) else $error("bad code runs");
	property p_resetIdle;
		$fell(sys_rst) |-> !opActive && !hvEnable && flashCmd == 8'h00;
	endproperty
	a_resetIdle: assert property (p_resetIdle) else $error("not idle");
	property p_startLaunch;
		$rose(opActive) |-> launchPending;
	endproperty
	a_startLaunch: assert property (p_startLaunch) else $error("no launch");
	property p_stopAbort;
		(hvEnable && stopRequest) [*2] |-> ##[1:3] !hvEnable;
	endproperty
	a_stopAbort: assert property (p_stopAbort) else $error("no abort");

	c_mass: cover property ($rose(opActive) && flashCmd == 8'h41);
	c_page: cover property ($rose(opActive) && flashCmd == 8'h40);
	c_stop: cover property (stopRequest && $fell(hvEnable));
endmodule : flash_command_sequencer_props

bind flash_command_sequencer flash_command_sequencer_props u_props (
	.mclk(mclk), .sys_rst(sys_rst), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.stopRequest(stopRequest), .arrayBlank(arrayBlank),
	.flashCmd(flashCmd), .flashAddr(flashAddr), .flashData(flashData),
	.opActive(opActive), .hvEnable(hvEnable));

// ---- cpu_bus_model.sv ----
`timescale 1ns/10ps
// ****************************************************************
// Processor side of the register bus
// ****************************************************************
module cpu_bus_model (
	input  wire logic        mclk,
	output logic      [16:0] avs_address,
	output logic             avs_read,
	output logic             avs_write,
	output logic      [31:0] avs_writedata,
	output logic      [3:0]  avs_byteenable,
	input  wire logic [31:0] avs_readdata,
	input  wire logic        avs_waitrequest
);
	initial begin
		avs_address    = 17'h00000;
		avs_read       = 1'h0;
		avs_write      = 1'h0;
		avs_writedata  = 32'h00000000;
		avs_byteenable = 4'h0;
	end

	// Waitrequest and read data are taken at the rising edge itself; the
	// request stands until the edge that completes it, then is released
	task automatic acc(input logic rd, input logic [16:0] a,
		input logic [31:0] d, input logic [3:0] be,
		output logic [31:0] q, output logic ok);
		ok = 1'h0;
		q  = 32'h00000000;
		@(posedge mclk);
		avs_address    <= a;
		avs_read       <= rd;
		avs_write      <= !rd;
		avs_writedata  <= d;
		avs_byteenable <= be;
		for (int i = 0; i < 20 && !ok; i++) begin
			@(posedge mclk);
			if (!avs_waitrequest) begin
				q  = avs_readdata;
				ok = 1'h1;
			end
		end
		avs_read      <= 1'h0;
		avs_write     <= 1'h0;
		avs_writedata <= ~d;
	endtask : acc

	task automatic cmd(input logic [15:0] a, input logic [7:0] d,
		input logic [7:0] c, output logic ok);
		logic [31:0] q;
		logic        ok1;
		logic        ok2;
		acc(1'h0, {1'h1, a}, {24'h000000, d}, 4'hF, q, ok);
		acc(1'h0, flash_seq_pkg::CMD_OFS, {24'h000000, c}, 4'hF, q, ok1);
		acc(1'h0, flash_seq_pkg::STAT_OFS, 32'h00000080, 4'hF, q, ok2);
		ok = ok && ok1 && ok2;
	endtask : cmd
endmodule : cpu_bus_model

// ---- flash_command_sequencer_bench.sv ----
`timescale 1ns/10ps
module flash_command_sequencer_bench;
	localparam int PG  = 20;
	localparam int MS  = 40;
	localparam int PER = 504;
	localparam logic [16:0] ST = flash_seq_pkg::STAT_OFS;
	localparam logic [16:0] DV = flash_seq_pkg::DIV_OFS;
	localparam logic [16:0] CM = flash_seq_pkg::CMD_OFS;
	typedef struct {
		logic [7:0]  cmd;
		logic [15:0] addr;
		logic [7:0]  data;
		int          len;
	} op_type;
	logic        mclk;
	logic        sys_rst;
	logic [16:0] avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [3:0]  avs_byteenable;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        stopRequest;
	logic        arrayBlank;
	logic [7:0]  flashCmd;
	logic [15:0] flashAddr;
	logic [7:0]  flashData;
	logic        opActive;
	logic        hvEnable;
	logic        opPrev;
	logic        opEnd;
	logic        opStart;
	logic        okLen;
	logic [15:0] addrPrev;
	logic [15:0] rdNote;
	logic [31:0] rdMask;
	logic [31:0] rdExp;
	int          fails;
	int          compares;
	int          seed;
	int          cyc;
	int          t0;
	op_type      cur;
	op_type      expOp[$];
	logic [15:0] expRd[$];

	flash_command_sequencer #(.PAGE_ERASE_TICKS(PG), .MASS_ERASE_TICKS(MS))
		dut (.mclk(mclk), .sys_rst(sys_rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.stopRequest(stopRequest), .arrayBlank(arrayBlank),
		.flashCmd(flashCmd), .flashAddr(flashAddr), .flashData(flashData),
		.opActive(opActive), .hvEnable(hvEnable));
	cpu_bus_model cpu (.mclk(mclk), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

	// ****************************************************************
	// Checking and closing
	// ****************************************************************
	task automatic check(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	task automatic end_sim;
		$display("fails %0d compares %0d", fails, compares);
		if (fails == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_sim

	task automatic hang;
		check("wait bound", 1, 0);
		end_sim();
	endtask : hang

	// ****************************************************************
	// Bus helpers
	// ****************************************************************
	task automatic wr(input logic [16:0] a, input logic [7:0] d,
		input logic [3:0] be = 4'hF);
		logic [31:0] q;
		logic        ok;
		cpu.acc(1'h0, a, {24'h000000, d}, be, q, ok);
		if (!ok) hang();
	endtask : wr

	task automatic rd(input logic [16:0] a, input logic [7:0] e,
		input logic [7:0] m = 8'hFF);
		logic [31:0] q;
		logic        ok;
		expRd.push_back({m, e});
		cpu.acc(1'h1, a, 32'h00000000, 4'hF, q, ok);
		if (!ok) hang();
	endtask : rd

	task automatic waitIdle;
		int n;
		for (n = 0; n < 30000 && opActive; n++)
			@(posedge mclk);
		if (opActive) hang();
	endtask : waitIdle

	task automatic run(input logic [7:0] c, input int ticks);
		op_type e;
		logic   ok;
		e.addr = 16'($random(seed));
		e.data = 8'($random(seed));
		e.cmd  = c;
		e.len  = ticks * PER;
		expOp.push_back(e);
		cpu.cmd(e.addr, e.data, c, ok);
		if (!ok) hang();
		rd(ST, 8'h80);
	endtask : run

	task automatic errClear;
		rd(ST, 8'h10, 8'h10);
		wr(ST, 8'h10);
		rd(ST, 8'hC0);
	endtask : errClear

	// Second burst byte queued behind the first on the same row
	task automatic chain;
		op_type e;
		logic   ok;
		e.cmd  = 8'h25;
		e.data = 8'($random(seed));
		e.addr = {8'($random(seed)), 8'h10};
		e.len  = 9 * PER;
		expOp.push_back(e);
		cpu.cmd(e.addr, e.data, e.cmd, ok);
		if (!ok) hang();
		e.addr = e.addr + 16'h0001;
		e.len  = 4 * PER;
		cpu.cmd(e.addr, e.data, e.cmd, ok);
		if (!ok) hang();
		expOp.push_back(e);
		rd(ST, 8'h00, 8'hC0);
	endtask : chain

	// ****************************************************************
	// Result watcher
	// ****************************************************************
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (avs_read && !avs_waitrequest && expRd.size() > 0) begin
			rdNote = expRd.pop_front();
			rdMask = {24'h000000, rdNote[15:8]};
			rdExp  = rdMask & {24'h000000, rdNote[7:0]};
			check("readback", avs_readdata & rdMask, rdExp);
		end
		// A queued command starts as the previous ends: new address
		opEnd   = opPrev && (!opActive || flashAddr !== addrPrev);
		opStart = opActive && (!opPrev || flashAddr !== addrPrev);
		okLen   = cyc - t0 >= cur.len && cyc - t0 <= cur.len + 3;
		if (opEnd && cur.len > 0)
			check("duration", okLen, 1);
		if (opStart) begin
			t0 = cyc;
			check("start", expOp.size(), 1);
			if (expOp.size() > 0) cur = expOp.pop_front();
			if (cur.cmd == 8'h40) cur.addr[8:0] = 9'h000;
			check("command", flashCmd, cur.cmd);
			check("address", flashAddr, cur.addr);
			if (cur.cmd inside {8'h20, 8'h25})
				check("data", flashData, cur.data);
		end
		opPrev   = opActive;
		addrPrev = flashAddr;
	end

	initial begin
		mclk = 1'h0;
		forever #5 mclk = ~mclk;
	end

	initial begin
		repeat (90000) @(posedge mclk);
		hang();
	end

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		logic [7:0] codes[5];
		int         ticks[5];
		codes = '{8'h05, 8'h20, 8'h25, 8'h40, 8'h41};
		ticks = '{16, 9, 9, PG, MS};
		seed = 82;
		fails = 0;
		compares = 0;
		cyc = 0;
		opPrev = 1'h0;
		sys_rst = 1'h1;
		stopRequest = 1'h0;
		arrayBlank = 1'h1;
		repeat (16) @(posedge mclk);
		sys_rst <= 1'h0;
		rd(ST, 8'hC0);
		rd(DV, 8'h00);
		wr(17'h10000 | 17'($random(seed) & 16'hFFFF), 8'h5A);
		wr(DV, 8'h7E);
		rd(DV, 8'h00);
		wr(ST, 8'h10, 4'h0);
		rd(ST, 8'h10, 8'h10);
		wr(ST, 8'h10);
		rd(ST, 8'hC0);
		wr(DV, 8'h7E);
		rd(DV, 8'hFE);
		wr(DV, 8'h41);
		rd(DV, 8'hFE);
		foreach (codes[i]) begin
			run(codes[i], ticks[i]);
			waitIdle();
			rd(ST, {5'h18, codes[i] == 8'h05, 2'h0});
		end
		chain();
		waitIdle();
		rd(ST, 8'hC0);
		wr(17'h10123, 8'h11);
		wr(ST, 8'h00);
		errClear();
		wr(17'h10200, 8'h22);
		wr(CM, 8'h33);
		wr(ST, 8'h80);
		repeat (8) @(posedge mclk);
		check("refused start", opActive, 0);
		errClear();
		wr(CM, 8'h20);
		errClear();
		run(8'h41, 0);
		repeat (50) @(posedge mclk);
		stopRequest <= 1'h1;
		waitIdle();
		stopRequest <= 1'h0;
		errClear();
		rd(17'h0000C, 8'h00);
		@(posedge mclk);
		sys_rst <= 1'h1;
		repeat (3) @(posedge mclk);
		sys_rst <= 1'h0;
		rd(ST, 8'hC0);
		rd(DV, 8'h00);
		repeat (4) @(posedge mclk);
		check("pending ops", expOp.size(), 0);
		end_sim();
	end
endmodule : flash_command_sequencer_bench
